// ==== core/pclc_defs.vh ====
`ifndef PCLC_DEFS_VH
`define PCLC_DEFS_VH

// Register offsets (12-bit byte addresses)
`define PCLC_OFS_PC_LOW   12'h002
`define PCLC_OFS_LATCH    12'h00A
`define PCLC_OFS_STAT_SH  12'hFE4
`define PCLC_OFS_WREG_SH  12'hFE5
`define PCLC_OFS_BSR_SH   12'hFE6
`define PCLC_OFS_LATH_SH  12'hFE7
`define PCLC_OFS_P0L_SH   12'hFE8
`define PCLC_OFS_P0H_SH   12'hFE9
`define PCLC_OFS_P1L_SH   12'hFEA
`define PCLC_OFS_P1H_SH   12'hFEB
`define PCLC_OFS_STK_PTR  12'hFED
`define PCLC_OFS_TOP_LO   12'hFEE
`define PCLC_OFS_TOP_HI   12'hFEF

// Field widths
`define PCLC_PC_W         15
`define PCLC_PC_HI_W      7
`define PCLC_SP_W         5
`define PCLC_STAT_W       3
`define PCLC_BSR_W        5

// Reset values
`define PCLC_PC_RST       15'h0000
`define PCLC_SP_RST       5'h1F
`define PCLC_LATCH_RST    7'h00

`endif

// ==== core/pclc_shadow.v ====
`timescale 1ns/1ps
`include "pclc_defs.vh"

// Context shadow bank; no reset so contents survive every reset
module pclc_shadow
(
    input  wire        clk,      // Core clock
    input  wire        save,     // Capture live context
    input  wire [7:0]  live_w,   // Live working register
    input  wire [2:0]  live_st,  // Live status flags
    input  wire [4:0]  live_bsr, // Live bank select
    input  wire [6:0]  live_lat, // Live page latch
    input  wire [15:0] live_p0,  // Live pointer 0
    input  wire [15:0] live_p1,  // Live pointer 1
    input  wire        wr,       // Software write strobe
    input  wire [11:0] addr,     // Software address
    input  wire [7:0]  wdata,    // Software write data
    output reg  [7:0]  rdata,    // Combinational read value
    output reg         hit       // Address is a shadow register
);
    reg [7:0] sh_q [0:7];
    wire      in_range;
    wire [2:0] idx;

    assign in_range = (addr >= `PCLC_OFS_STAT_SH) && (addr <= `PCLC_OFS_P1H_SH);
    assign idx      = addr[2:0] - 3'h4;

    // No reset branch: unknown at power-on, unchanged on later resets
    always @(posedge clk)
    begin
        if (save)
        begin
            sh_q[0] <= {5'h00, live_st};
            sh_q[1] <= live_w;
            sh_q[2] <= {3'h0, live_bsr};
            sh_q[3] <= {1'b0, live_lat};
            sh_q[4] <= live_p0[7:0];
            sh_q[5] <= live_p0[15:8];
            sh_q[6] <= live_p1[7:0];
            sh_q[7] <= live_p1[15:8];
        end
        else if (wr && in_range)
        begin
            sh_q[idx] <= wdata;
        end
    end

    always @*
    begin
        hit   = in_range;
        rdata = 8'h00;
        if (in_range)
        begin
            case (idx)
                3'h0:    rdata = {5'h00, sh_q[0][2:0]};
                3'h2:    rdata = {3'h0, sh_q[2][4:0]};
                3'h3:    rdata = {1'b0, sh_q[3][6:0]};
                default: rdata = sh_q[idx];
            endcase
        end
    end
endmodule

// ==== core/pclc_stack.v ====
`timescale 1ns/1ps
`include "pclc_defs.vh"

// Stack pointer plus top-of-stack window onto the return stack
module pclc_stack
#(
    parameter DEPTH = 16                // Stack levels
)
(
    input  wire        clk,             // Core clock
    input  wire        rst_n,           // Async reset, active low
    input  wire        wr,              // Software write strobe
    input  wire [11:0] addr,            // Software address
    input  wire [7:0]  wdata,           // Software write data
    output reg  [7:0]  rdata,           // Combinational read value
    output reg         hit,             // Address is a stack register
    output wire [4:0]  sp               // Current stack pointer
);
    reg [4:0]  sp_q;
    reg [14:0] mem_q [0:DEPTH-1];
    wire [3:0] slot;

    assign sp   = sp_q;
    assign slot = sp_q[3:0];

    // Five bits so 0x1F (empty) and 0x10 (overflow) are distinct
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sp_q <= `PCLC_SP_RST;
        else if (wr && addr == `PCLC_OFS_STK_PTR)
            sp_q <= wdata[4:0];
    end

    always @(posedge clk)
    begin
        if (wr && addr == `PCLC_OFS_TOP_LO)
            mem_q[slot] <= {mem_q[slot][14:8], wdata};
        else if (wr && addr == `PCLC_OFS_TOP_HI)
            mem_q[slot] <= {wdata[6:0], mem_q[slot][7:0]};
    end

    always @*
    begin
        hit   = 1'b1;
        rdata = 8'h00;
        case (addr)
            `PCLC_OFS_STK_PTR: rdata = {3'h0, sp_q};
            `PCLC_OFS_TOP_LO:  rdata = mem_q[slot][7:0];
            `PCLC_OFS_TOP_HI:  rdata = {1'b0, mem_q[slot][14:8]};
            default:           hit   = 1'b0;
        endcase
    end
endmodule

// ==== core/pclc_top.v ====
`timescale 1ns/1ps
`include "pclc_defs.vh"

//Contract
// - The program counter is a 15-bit register made of an 8-bit low part and a 7-bit high part.
// - Software can read and write the low eight counter bits as a register.
// - The upper counter bits have no direct access and are loaded only from the page latch; the code also changes them by carry on a fetch increment.
// - Every reset clears the whole program counter to zero.
// - A write to the low counter register also copies the page latch into the upper seven bits.
// - After a low-register write the counter equals page latch bits joined with the written byte.
// - Shadow copies of context registers are unknown at power-on and kept across other resets.
// - The stack pointer is five bits wide so overflow and underflow show in its value.
module pclc_top
(
    input  wire        clk,          // Core clock, 250 MHz
    input  wire        rst_n,        // Async reset, active low
    input  wire        fetch,        // One instruction fetched
    input  wire        ctx_save,     // Capture context into shadows
    input  wire [7:0]  live_w,       // Live working register
    input  wire [2:0]  live_st,      // Live status flags
    input  wire [4:0]  live_bsr,     // Live bank select
    input  wire [15:0] live_p0,      // Live pointer 0
    input  wire [15:0] live_p1,      // Live pointer 1
    input  wire [11:0] reg_addr,     // Register address
    input  wire [7:0]  reg_wdata,    // Register write data
    input  wire        reg_wr,       // Write strobe
    input  wire        reg_rd,       // Read strobe
    output reg  [7:0]  reg_rdata,    // Read data, cycle after strobe
    output reg  [14:0] prog_count,   // Full program counter
    output reg  [6:0]  page_latch,   // Page latch value
    output reg  [4:0]  stack_ptr     // Stack pointer value
);
    reg  [7:0] prog_count_low_q;
    reg  [6:0] prog_count_high_q;
    reg  [6:0] page_latch_q;
    reg  [7:0] rdata_d;
    wire       wr_low;
    wire       wr_lat;
    wire [7:0] sh_rdata;
    wire       sh_hit;
    wire [7:0] stk_rdata;
    wire       stk_hit;
    wire [4:0] sp;

    assign wr_low = reg_wr && (reg_addr == `PCLC_OFS_PC_LOW);
    assign wr_lat = reg_wr && (reg_addr == `PCLC_OFS_LATCH);

    function [14:0] pclc_inc;
        input [14:0] pc;
        begin
            pclc_inc = pc + 15'h0001;
        end
    endfunction

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            page_latch_q <= `PCLC_LATCH_RST;
        else if (wr_lat)
            page_latch_q <= reg_wdata[6:0];
    end

    // Low-byte write beats increment when both land in one cycle
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_count_low_q  <= 8'h00;
            prog_count_high_q <= 7'h00;
        end
        else if (wr_low)
        begin
            prog_count_low_q  <= reg_wdata;
            prog_count_high_q <= page_latch_q;
        end
        else if (fetch)
        begin
            {prog_count_high_q, prog_count_low_q} <=
                pclc_inc({prog_count_high_q, prog_count_low_q});
        end
    end

    pclc_shadow u_shadow
    (
        .clk      (clk),
        .save     (ctx_save),
        .live_w   (live_w),
        .live_st  (live_st),
        .live_bsr (live_bsr),
        .live_lat (page_latch_q),
        .live_p0  (live_p0),
        .live_p1  (live_p1),
        .wr       (reg_wr),
        .addr     (reg_addr),
        .wdata    (reg_wdata),
        .rdata    (sh_rdata),
        .hit      (sh_hit)
    );

    pclc_stack #(.DEPTH(16)) u_stack
    (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (reg_wr),
        .addr  (reg_addr),
        .wdata (reg_wdata),
        .rdata (stk_rdata),
        .hit   (stk_hit),
        .sp    (sp)
    );

    // Upper counter bits deliberately absent from the read map
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_addr == `PCLC_OFS_PC_LOW)
            rdata_d = prog_count_low_q;
        else if (reg_addr == `PCLC_OFS_LATCH)
            rdata_d = {1'b0, page_latch_q};
        else if (sh_hit)
            rdata_d = sh_rdata;
        else if (stk_hit)
            rdata_d = stk_rdata;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 8'h00;
            prog_count <= `PCLC_PC_RST;
            page_latch <= `PCLC_LATCH_RST;
            stack_ptr  <= `PCLC_SP_RST;
        end
        else
        begin
            reg_rdata  <= reg_rd ? rdata_d : 8'h00;
            prog_count <= {prog_count_high_q, prog_count_low_q};
            page_latch <= page_latch_q;
            stack_ptr  <= sp;
        end
    end
endmodule

// ==== verif/pclc_chk_assertions.sv ====
`timescale 1ns/1ps
module pclc_chk
(
    input wire        clk,
    input wire        rst_n,
    input wire        fetch,
    input wire [11:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire [14:0] prog_count,
    input wire [6:0]  page_latch,
    input wire [4:0]  stack_ptr
);
    reg  [6:0]  lat_q;
    reg  [14:0] exp_q;
    wire        pw = reg_wr && reg_addr == 12'h002;
    wire        lw = reg_wr && reg_addr == 12'h00A;
    // Mirror of the latch, so expectations never use the design's own copy
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            lat_q <= 7'h00;
        else if (lw)
            lat_q <= reg_wdata[6:0];
    always @(posedge clk)
        if (pw)
            exp_q <= {lat_q, reg_wdata};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A second load right behind would move the mirror before the check
    sequence low_s;
        pw ##1 !pw;
    endsequence
    sequence lat_s;
        lw ##1 !lw;
    endsequence
    pc_rst_a: assert property ($rose(rst_n) |-> prog_count == 15'h0000)
        else $error("counter not clear after reset");
    sp_rst_a: assert property ($rose(rst_n) |-> stack_ptr == 5'h1F)
        else $error("stack pointer not at top after reset");
    pc_load_a: assert property (low_s |-> ##[0:1] prog_count == exp_q)
        else $error("counter not loaded from latch and low byte");
    pc_hold_a: assert property ((!fetch && !pw) [*2] |=> $stable(prog_count))
        else $error("counter moved without cause");
    pc_inc_a: assert property (fetch && !pw |-> ##2 prog_count == $past(prog_count) + 15'h0001)
        else $error("counter did not advance by one");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    rd_hole_a: assert property (reg_rd && reg_addr == 12'hFEC |=> reg_rdata == 8'h00)
        else $error("hole in shadow bank not zero");
    lat_rd_a: assert property (reg_rd && reg_addr == 12'h00A |=> reg_rdata == {1'b0, lat_q})
        else $error("latch read wrong");
    lat_out_a: assert property (lat_s |-> ##[0:1] page_latch == lat_q)
        else $error("latch output wrong");
    sp_rd_a: assert property (reg_rd && reg_addr == 12'hFED |=> reg_rdata[7:5] == 3'h0)
        else $error("stack pointer wider than five bits");
endmodule
bind pclc_top pclc_chk u_chk
(
    .clk(clk), .rst_n(rst_n), .fetch(fetch), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_count(prog_count),
    .page_latch(page_latch), .stack_ptr(stack_ptr)
);

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         fetch = 1'b0;
    reg         ctx_save = 1'b0;
    reg  [11:0] reg_addr = 12'h000;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [7:0]  reg_rdata;
    wire [14:0] prog_count;
    wire [6:0]  page_latch;
    wire [4:0]  stack_ptr;
    reg  [7:0]  rv;
    reg  [63:0] ev;
    integer     err_count = 0;
    integer     total_checks = 0;
    integer     cyc = 0;
    integer     i;
    always #2 clk = ~clk;
    pclc_top dut
    (
        .clk(clk), .rst_n(rst_n), .fetch(fetch), .ctx_save(ctx_save), .live_w(8'hA5),
        .live_st(3'h5), .live_bsr(5'h13), .live_p0(16'h1234), .live_p1(16'hBEEF),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .prog_count(prog_count), .page_latch(page_latch),
        .stack_ptr(stack_ptr)
    );
    task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("FAIL %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 rv = reg_rdata;
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task t_reset;
        begin
            chk("pc0", prog_count, 15'h0000);
            rd(12'hFED);
            chk("sp0", rv, 8'h1F);
        end
    endtask
    // Pointer picks the slot; upper stack byte keeps only seven bits
    task t_stk;
        begin
            wr(12'hFED, 8'hE3);
            wr(12'hFEE, 8'hA5);
            wr(12'hFEF, 8'hFF);
            rd(12'hFED);
            chk("sp", rv, 8'h03);
            chk("sp_out", stack_ptr, 5'h03);
            rd(12'hFEE);
            chk("tos_lo", rv, 8'hA5);
            rd(12'hFEF);
            chk("tos_hi", rv, 8'h7F);
            rd(12'hFEC);
            chk("gap", rv, 8'h00);
        end
    endtask
    task t_load;
        begin
            wr(12'h00A, 8'hD5);
            wr(12'h002, 8'hFF);
            repeat (2) @(posedge clk);
            #1 chk("pc", prog_count, 15'h55FF);
            rd(12'h00A);
            chk("latch", rv, 8'h55);
            rd(12'h002);
            chk("low", rv, 8'hFF);
            @(posedge clk);
            fetch <= 1'b1;
            @(posedge clk);
            fetch <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk("carry", prog_count, 15'h5600);
        end
    endtask
    // Load and fetch in one cycle: the load must win
    task t_race;
        begin
            wr(12'h00A, 8'h7F);
            @(posedge clk);
            fetch <= 1'b1;
            wr(12'h002, 8'h00);
            fetch <= 1'b0;
            wr(12'h003, 8'h11);
            repeat (2) @(posedge clk);
            #1 chk("race", prog_count, 15'h7F00);
            rd(12'h003);
            chk("hole", rv, 8'h00);
        end
    endtask
    task t_shad;
        for (i = 0; i < 8; i = i + 1)
        begin
            rd(12'hFE4 + i[11:0]);
            chk("shadow", rv, ev[8*i +: 8]);
        end
    endtask
    // Capture, overwrite one shadow, then a mid-run reset must keep them
    task t_ctx;
        begin
            ev = {8'hBE, 8'hEF, 8'h12, 8'h34, 8'h7F, 8'h13, 8'h3C, 8'h05};
            @(posedge clk);
            ctx_save <= 1'b1;
            @(posedge clk);
            ctx_save <= 1'b0;
            wr(12'hFE5, 8'h3C);
            t_shad;
            @(posedge clk);
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            chk("pc_rst", prog_count, 15'h0000);
            chk("sp_rst", stack_ptr, 5'h1F);
            rst_n <= 1'b1;
            t_shad;
        end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 2000)
        begin
            err_count = err_count + 1;
            results;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_load;
        t_race;
        t_stk;
        t_ctx;
        results;
    end
endmodule
